/* design/i2cme_map.svh */
// constants for the i2c master event controller
`ifndef I2CME_MAP_SVH
`define I2CME_MAP_SVH
`define I2CME_CON2_START 0
`define I2CME_CON2_RSTART 1
`define I2CME_CON2_STOP 2
`define I2CME_CON2_RECV 3
`define I2CME_CON2_ACK_START_BIT 4
`define I2CME_CON2_ACK_VALUE_BIT 5
`define I2CME_EVENT_MASK 5'h1F
`define I2CME_CON1_WRITE_COLLISION_BIT 7
`define I2CME_CON1_EN 5
`define I2CME_FIRST_PERIPHERAL_FLAG_REGISTER_EVENT 3
`define I2CME_SECOND_PERIPHERAL_FLAG_REGISTER_BCOL 3
`define I2CME_RATE_DIV 4
`define I2CME_RATE_RST 7'h09
`define I2CME_BITS 4'h8
`endif

/* design/i2cme_pkg.sv */
// types for the i2c master event controller
package i2cme_pkg;
	typedef enum logic [2:0] {
		I2CME_IDLE, I2CME_START, I2CME_RSTART, I2CME_STOP,
		I2CME_RECV, I2CME_ACK, I2CME_XMIT
	} i2cme_state_t;
endpackage

/* design/i2cme_sync.sv */
// two-flop synchroniser for one bus line
`timescale 1ns/100ps
module i2cme_sync (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic din,
	output logic dout
);
	logic meta_q;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_q <= 1'b1;
			dout <= 1'b1;
		end else begin
			meta_q <= din;
			dout <= meta_q;
		end
	end
endmodule // i2cme_sync

/* design/i2cme_ctrl.sv */
// i2c master event engine: start, restart, stop, receive, ack, transmit
//
// Functional notes
// - start, restart, stop, receive begin when their control bit is set
// - ack value is written first, then ack start drives it on bus
// - master clocks the ninth pulse, releases data when transmitting
// - receiver holds data low through the ack pulse high phase
// - ack event drives low for value 0, releases high for value 1
// - writing the buffer starts a one-byte transmit
// - no queuing; software waits for idle before the next event
// - event bits stay set while running, clear themselves on completion
// - idle means five low event bits zero and transmit flag clear
// - transmit-in-progress flag set during transmit, cleared at end
// - every completed event sets the event interrupt flag
// - buffer write or event start while busy sets write collision
// - write collision raises no interrupt, only its status bit
// - bus collision in start, restart, stop, data sets collision flag
// - a one on data is sent by releasing the line
// - data low when expected high with clock high is a collision
// - bit rate from reload value: fosc over four times rate, minus one
// - port enable hands clock and data pins to the engine
// - bytes are eight bits msb first plus a ninth ack clock
// - collision aborts condition, releases lines, clears event bits
`timescale 1ns/100ps
`include "i2cme_map.svh"
module i2cme_ctrl (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic port_enable_bit,
	input wire logic [6:0] rate_reload,
	input wire logic [4:0] event_set,
	input wire logic ack_value_wr,
	input wire logic ack_value_in,
	input wire logic buf_wr,
	input wire logic [7:0] buf_wdata,
	input wire logic buf_rd,
	input wire logic event_flag_clr,
	input wire logic write_collision_bit_clr,
	input wire logic bcol_clr,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic scl_out,
	output logic scl_oe,
	output logic sda_out,
	output logic sda_oe,
	output logic [4:0] event_bits,
	output logic ack_value_bit,
	output logic xmit_busy,
	output logic buf_full,
	output logic [7:0] buf_rdata,
	output logic ack_stat,
	output logic event_interrupt_flag,
	output logic write_collision_bit,
	output logic bus_collision_flag
);
	import i2cme_pkg::*;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic scl_s, sda_s;
	i2cme_sync u_sync_scl (.clk(clk), .rst_n(rst_n), .din(scl_in),
		.dout(scl_s));
	i2cme_sync u_sync_sda (.clk(clk), .rst_n(rst_n), .din(sda_in),
		.dout(sda_s));

	// ----------------------------------------------------------------
	// quarter-bit tick
	// ----------------------------------------------------------------
	// each bit is four ticks of (reload+1) clocks
	logic [6:0] div_q;
	logic tick;
	assign tick = (div_q == 7'h00);
	always_ff @(posedge clk) begin
		if (!rst_n || !port_enable_bit)
			div_q <= 7'h00;
		else if (tick)
			div_q <= rate_reload;
		else
			div_q <= div_q - 7'h01;
	end

	// ----------------------------------------------------------------
	// event sequencer
	// ----------------------------------------------------------------
	i2cme_state_t state_q;
	logic [1:0] ph_q;
	logic [3:0] bit_q;
	logic [7:0] shift_q;
	logic busy, start_req, bcol_hit, done;
	logic exp_high;

	assign busy = (state_q != I2CME_IDLE) || xmit_busy ||
		(event_bits != 5'h00);
	assign start_req = (event_set != 5'h00) || buf_wr;

	// data released means we expect high; checked with clock high.
	// the synchronised level lags the pin by two clocks, so a line
	// we have just let go still reads low; wait for it to settle
	logic [2:0] oe_hist_q;
	always_ff @(posedge clk) begin
		if (!rst_n)
			oe_hist_q <= 3'h0;
		else
			oe_hist_q <= {oe_hist_q[1:0], sda_oe};
	end
	assign exp_high = !sda_oe && (oe_hist_q == 3'h0);
	assign bcol_hit = (state_q != I2CME_IDLE) && (state_q != I2CME_RECV) &&
		exp_high && scl_s && !sda_s && scl_oe == 1'b0 &&
		!(state_q == I2CME_XMIT && bit_q == `I2CME_BITS) &&
		!(state_q == I2CME_ACK && ack_value_bit);

	// a condition ends after four ticks; a transmit after nine bits.
	// receive stops after eight: the ack event clocks the ninth
	assign done = tick && ph_q == 2'd3 &&
		((state_q == I2CME_START) || (state_q == I2CME_RSTART) ||
		 (state_q == I2CME_STOP) || (state_q == I2CME_ACK) ||
		 (state_q == I2CME_XMIT && bit_q == `I2CME_BITS) ||
		 (state_q == I2CME_RECV && bit_q == 4'h7));

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q <= I2CME_IDLE;
		end else if (!port_enable_bit || bcol_hit) begin
			state_q <= I2CME_IDLE;
		end else if (state_q == I2CME_IDLE && !busy && start_req) begin
			if (buf_wr)
				state_q <= I2CME_XMIT;
			else if (event_set[`I2CME_CON2_START])
				state_q <= I2CME_START;
			else if (event_set[`I2CME_CON2_RSTART])
				state_q <= I2CME_RSTART;
			else if (event_set[`I2CME_CON2_STOP])
				state_q <= I2CME_STOP;
			else if (event_set[`I2CME_CON2_RECV])
				state_q <= I2CME_RECV;
			else
				state_q <= I2CME_ACK;
		end else if (done) begin
			state_q <= I2CME_IDLE;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || state_q == I2CME_IDLE) begin
			ph_q <= 2'd0;
			bit_q <= 4'h0;
		end else if (tick) begin
			ph_q <= ph_q + 2'd1;
			if (ph_q == 2'd3)
				bit_q <= bit_q + 4'h1;
		end
	end

	// ----------------------------------------------------------------
	// control and status bits
	// ----------------------------------------------------------------
	logic accept;
	assign accept = state_q == I2CME_IDLE && !busy && start_req &&
		port_enable_bit;

	always_ff @(posedge clk) begin
		if (!rst_n || !port_enable_bit || bcol_hit) begin
			event_bits <= 5'h00;
		end else if (accept && !buf_wr) begin
			event_bits <= event_set;
		end else if (done && state_q != I2CME_XMIT) begin
			event_bits <= 5'h00;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			ack_value_bit <= 1'b0;
		else if (ack_value_wr)
			ack_value_bit <= ack_value_in;
	end

	always_ff @(posedge clk) begin
		if (!rst_n || !port_enable_bit || bcol_hit)
			xmit_busy <= 1'b0;
		else if (accept && buf_wr)
			xmit_busy <= 1'b1;
		else if (done && state_q == I2CME_XMIT)
			xmit_busy <= 1'b0;
	end

	// refused requests are dropped; only the status bit records them
	always_ff @(posedge clk) begin
		if (!rst_n)
			write_collision_bit <= 1'b0;
		else if (start_req && busy)
			write_collision_bit <= 1'b1;
		else if (write_collision_bit_clr)
			write_collision_bit <= 1'b0;
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			event_interrupt_flag <= 1'b0;
		else if (done)
			event_interrupt_flag <= 1'b1;
		else if (event_flag_clr)
			event_interrupt_flag <= 1'b0;
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			bus_collision_flag <= 1'b0;
		else if (bcol_hit)
			bus_collision_flag <= 1'b1;
		else if (bcol_clr)
			bus_collision_flag <= 1'b0;
	end

	// ----------------------------------------------------------------
	// shift register, buffer and ack capture
	// ----------------------------------------------------------------
	logic tx_shift, rx_sample;
	// transmit moves on while the clock is low; receive samples in the
	// last clock of the high phase, before the far side changes the line
	assign tx_shift = tick && ph_q == 2'd3 && bit_q < `I2CME_BITS &&
		state_q == I2CME_XMIT;
	assign rx_sample = tick && ph_q == 2'd2 && bit_q < `I2CME_BITS &&
		state_q == I2CME_RECV;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			shift_q <= 8'h00;
		end else if (accept && buf_wr) begin
			shift_q <= buf_wdata;
		end else if (tx_shift || rx_sample) begin
			shift_q <= {shift_q[6:0], sda_s};
		end
	end

	// sample point is the last clock of the high phase of the clock
	always_ff @(posedge clk) begin
		if (!rst_n)
			ack_stat <= 1'b0;
		else if (tick && ph_q == 2'd2 && bit_q == `I2CME_BITS &&
			state_q == I2CME_XMIT)
			ack_stat <= sda_s;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			buf_rdata <= 8'h00;
			buf_full <= 1'b0;
		end else if (accept && buf_wr) begin
			buf_rdata <= buf_wdata;
			buf_full <= 1'b1;
		end else if (rx_sample && bit_q == 4'h7) begin
			buf_rdata <= {shift_q[6:0], sda_s};
			buf_full <= 1'b1;
		end else if (buf_rd || (done && state_q == I2CME_XMIT) ||
			bcol_hit) begin
			buf_full <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// pin drive; oe high pulls the line low
	// ----------------------------------------------------------------
	logic scl_low_d, sda_low_d;
	always_comb begin
		scl_low_d = 1'b0;
		sda_low_d = 1'b0;
		unique case (state_q)
			I2CME_IDLE: begin
				scl_low_d = scl_oe;
				sda_low_d = sda_oe;
			end
			I2CME_START: begin
				sda_low_d = ph_q >= 2'd2;
				scl_low_d = ph_q == 2'd3;
			end
			I2CME_RSTART: begin
				scl_low_d = ph_q == 2'd0;
				sda_low_d = ph_q == 2'd3;
			end
			I2CME_STOP: begin
				scl_low_d = ph_q == 2'd0;
				sda_low_d = ph_q <= 2'd1;
			end
			I2CME_ACK: begin
				scl_low_d = ph_q == 2'd0 || ph_q == 2'd3;
				sda_low_d = !ack_value_bit;
			end
			I2CME_RECV: begin
				scl_low_d = ph_q == 2'd0 || ph_q == 2'd3;
				sda_low_d = 1'b0;
			end
			I2CME_XMIT: begin
				scl_low_d = ph_q == 2'd0 || ph_q == 2'd3;
				// ones and the ack slot float high
				sda_low_d = bit_q < `I2CME_BITS &&
					!shift_q[7];
			end
		endcase
		if (!port_enable_bit || bcol_hit) begin
			scl_low_d = 1'b0;
			sda_low_d = 1'b0;
		end
	end

	// open drain: the driven level is always low
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			scl_oe <= 1'b0;
			scl_out <= 1'b0;
		end else begin
			scl_oe <= scl_low_d;
			scl_out <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sda_oe <= 1'b0;
			sda_out <= 1'b0;
		end else begin
			sda_oe <= sda_low_d;
			sda_out <= 1'b0;
		end
	end
endmodule // i2cme_ctrl

/* verification/i2cme_slv.sv */
// i2c slave model: acks written bytes, returns a byte when reading
`timescale 1ns/100ps
module i2cme_slv (
	input wire logic scl,
	input wire logic sda,
	input wire logic rd_mode,
	input wire logic ack_en,
	input wire logic [7:0] rd_byte,
	output logic pull
);
	int cnt = 0;
	int slot;
	always @(negedge sda) if (scl) cnt = 0;
	always @(posedge sda) if (scl) cnt = 0;
	always @(negedge scl) cnt = cnt + 1;
	// changes after a falling clock, and drops on a start or stop; nack leaves it to the pull-up
	always_comb begin
		slot = (cnt + 8) % 9;
		if (cnt == 0) pull = 1'b0;
		else if (rd_mode) pull = (slot < 8) && !rd_byte[7 - slot];
		else pull = (slot == 8) && ack_en;
	end
endmodule // i2cme_slv

/* verification/i2cme_ctrl_chk.sv */
// port assertions for the i2c master event engine
`timescale 1ns/100ps
module i2cme_ctrl_chk (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic port_enable_bit,
	input wire logic [4:0] event_set,
	input wire logic buf_wr,
	input wire logic scl_oe,
	input wire logic sda_oe,
	input wire logic [4:0] event_bits,
	input wire logic ack_value_bit,
	input wire logic xmit_busy,
	input wire logic buf_full,
	input wire logic event_interrupt_flag,
	input wire logic write_collision_bit,
	input wire logic bus_collision_flag
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic idle;
	assign idle = (event_bits == 5'h00) && !xmit_busy;
	sequence s_ok;
		idle && port_enable_bit && !bus_collision_flag;
	endsequence
	sequence s_ev;
		s_ok ##0 !buf_wr && $onehot(event_set);
	endsequence
	a_event_taken: assert property (s_ev |=> event_bits == $past(event_set))
		else $error("event bit not raised");
	a_xmit_taken: assert property (s_ok ##0 buf_wr && event_set == 5'h00 |=> xmit_busy && buf_full)
		else $error("transmit not started");
	a_write_collision_bit_busy: assert property (buf_wr && !idle |=> write_collision_bit)
		else $error("write collision missed");
	a_write_collision_bit_quiet: assert property (buf_wr && event_bits != 5'h00 && !event_interrupt_flag |=> !event_interrupt_flag || idle)
		else $error("collision raised event flag");
	a_done_flag: assert property ($rose(idle) && port_enable_bit |-> ##[0:1] (event_interrupt_flag || bus_collision_flag))
		else $error("no event flag at end");
	a_bcol_idle: assert property ($rose(bus_collision_flag) |-> ##[0:1] (idle && !sda_oe && !scl_oe))
		else $error("collision left engine busy");
	a_off_release: assert property (!port_enable_bit ##1 !port_enable_bit |-> !scl_oe && !sda_oe)
		else $error("pins held while off");
	a_ack_level: assert property (event_bits[4] && $fell(scl_oe) |-> sda_oe == !ack_value_bit)
		else $error("wrong ack level");
	a_rx_full: assert property ($fell(event_bits[3]) && !bus_collision_flag |-> buf_full)
		else $error("receive end without full");
endmodule // i2cme_ctrl_chk
bind i2cme_ctrl i2cme_ctrl_chk i_chk (.*);

/* verification/i2cme_ctrl_tb.sv */
// self-checking bench for the i2c master event engine
`timescale 1ns/100ps
module i2cme_ctrl_tb;
	logic clk = 1'b0, rst_n = 1'b0, port_enable_bit = 1'b0;
	logic [6:0] rate_reload = 7'h09;
	logic [4:0] event_set = 5'h00, event_bits;
	logic ack_value_wr = 1'b0, ack_value_in = 1'b0, buf_wr = 1'b0;
	logic [7:0] buf_wdata = 8'h00, buf_rdata, rd_byte = 8'h00;
	logic buf_rd = 1'b0, event_flag_clr = 1'b0, write_collision_bit_clr = 1'b0;
	logic bcol_clr = 1'b0, scl_in, sda_in, scl_out, scl_oe, sda_out, sda_oe;
	logic ack_value_bit, xmit_busy, buf_full, ack_stat, event_interrupt_flag;
	logic write_collision_bit, bus_collision_flag, pull, tb_pull = 1'b0;
	logic rd_mode = 1'b0, ack_en = 1'b1, b1 = 1'b0, b2 = 1'b0;
	logic [7:0] q[$];
	integer seed = 32'h83CA89B6;
	int err_total = 0, tests_run = 0;
	wire busy = (event_bits != 5'h00) || xmit_busy;
	// both lines pulled up; any party low wins
	assign scl_in = !scl_oe;
	assign sda_in = !(sda_oe || pull || tb_pull);
	i2cme_ctrl i_i2cme_ctrl (.*);
	i2cme_slv i_i2cme_slv (.scl(scl_in), .sda(sda_in), .rd_mode(rd_mode),
		.ack_en(ack_en), .rd_byte(rd_byte), .pull(pull));
	initial forever #12.5 clk = ~clk;
	task final_report;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] s, e);
		tests_run++;
		if (s !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task tick;
		@(posedge clk);
		#1;
	endtask
	task clr;
		{event_flag_clr, write_collision_bit_clr, bcol_clr, buf_rd} = 4'hF;
		tick;
		{event_flag_clr, write_collision_bit_clr, bcol_clr, buf_rd} = 4'h0;
	endtask
	task automatic go(input logic [4:0] e, input logic w, input logic [7:0] d);
		event_set = e;
		buf_wr = w;
		buf_wdata = d;
		tick;
		event_set = 5'h00;
		buf_wr = 1'b0;
	endtask
	task wait_idle;
		for (int i = 0; i < 3000 && busy; i++) tick;
		repeat (3) tick;
	endtask
	task automatic run(input logic [4:0] e, input logic w, input logic [7:0] d);
		clr;
		q.push_back(8'h01);
		go(e, w, d);
		tick;
		chk("running", {2'b00, event_bits, xmit_busy}, {2'b00, e, w});
		wait_idle;
		$display("event %h write %b done", e, w);
	endtask
	// completion notes are matched when the engine falls idle
	always @(posedge clk) begin
		b1 <= busy;
		b2 <= b1;
		if (b2 && !b1 && q.size() > 0)
			chk("done", {bus_collision_flag, event_interrupt_flag}, q.pop_front());
	end
	initial begin
		repeat (30000) @(posedge clk);
		err_total++;
		final_report;
	end
	initial begin
		repeat (4) @(posedge clk);
		#1 rst_n = 1'b1;
		repeat (3) tick;
		chk("reset", {event_bits, xmit_busy, buf_full, ack_value_bit}, 8'h00);
		port_enable_bit = 1'b1;
		tick;
		run(5'h01, 1'b0, 8'h00);
		run(5'h00, 1'b1, 8'($random(seed)));
		chk("ack", {7'h00, ack_stat}, 8'h00);
		for (int v = 0; v < 2; v++) begin
			rd_byte = 8'($random(seed));
			rd_mode = 1'b1;
			run(5'h08, 1'b0, 8'h00);
			chk("rx", buf_rdata, rd_byte);
			chk("full", {7'h00, buf_full}, 8'h01);
			ack_value_in = v[0];
			ack_value_wr = 1'b1;
			tick;
			ack_value_wr = 1'b0;
			run(5'h10, 1'b0, 8'h00);
			rd_mode = 1'b0;
		end
		run(5'h02, 1'b0, 8'h00);
		clr;
		go(5'h01, 1'b0, 8'h00);
		tick;
		q.push_back(8'h01);
		go(5'h00, 1'b1, 8'h5A);
		chk("write_collision_bit", {write_collision_bit, event_interrupt_flag, xmit_busy}, 8'h04);
		wait_idle;
		chk("kept", {xmit_busy, buf_full}, 8'h00);
		clr;
		go(5'h00, 1'b1, 8'hFF);
		tb_pull = 1'b1;
		wait_idle;
		chk("bcol", {bus_collision_flag, busy, sda_oe}, 8'h04);
		tb_pull = 1'b0;
		run(5'h01, 1'b0, 8'h00);
		ack_en = 1'b0;
		run(5'h00, 1'b1, 8'($random(seed)));
		chk("nack", {7'h00, ack_stat}, 8'h01);
		ack_en = 1'b1;
		run(5'h04, 1'b0, 8'h00);
		final_report;
	end
endmodule // i2cme_ctrl_tb
